// >>> rtl/spg_defines.svh
// Offsets, field positions, reset values and codes of the sector guard
`ifndef SPG_DEFINES_SVH
`define SPG_DEFINES_SVH

// ---------------------------------------------------------------------
// Geometry
// ---------------------------------------------------------------------
`define SPG_SECTORS 16
`define SPG_BLOCKS_PER_SECTOR 32
`define SPG_PWD_SLOTS 3

// ---------------------------------------------------------------------
// Guard word offsets in the area selected by wired_area_sel
// ---------------------------------------------------------------------
`define SPG_GUARD_WORD_0 11'h000
`define SPG_GUARD_WORD_1 11'h004
`define SPG_GUARD_WORD_2 11'h008
`define SPG_GUARD_WORD_3 11'h00c
`define SPG_GUARD_AREA_END 11'h010

// ---------------------------------------------------------------------
// Guard byte fields and reset values
// ---------------------------------------------------------------------
`define SPG_LOCK_BIT 0
`define SPG_PROT_LO 1
`define SPG_PROT_HI 2
`define SPG_PSEL_LO 3
`define SPG_PSEL_HI 4
`define SPG_GUARD_RESET 8'h00
`define SPG_PWD_RESET 32'h0000_0000

// ---------------------------------------------------------------------
// Protection and password-select codes
// ---------------------------------------------------------------------
`define SPG_PROT_PWD_WR 2'h0
`define SPG_PROT_OPEN 2'h1
`define SPG_PROT_PWD_RW 2'h2
`define SPG_PROT_PWD_RD 2'h3
`define SPG_PSEL_NONE 2'h0

`endif

// >>> rtl/spg_pkg.sv
// Types shared by the sector guard modules
`default_nettype none
package spg_pkg;
    // Contactless command kinds
    typedef enum logic [2:0] {
        spg_op_read,
        spg_op_write,
        spg_op_lock,
        spg_op_pwd_write,
        spg_op_present
    } spg_op_t;
    typedef logic [7:0] spg_guard_t;
    typedef logic [1:0] spg_pwd_sel_t;
endpackage
`default_nettype wire

// >>> rtl/spg_int_if.sv
// Internal carrier between the guard core, rights decode and password bank
`default_nettype none
interface spg_int_if #(parameter int N = 16);
    // Guard state and session grant
    logic [N-1:0][7:0] guard;
    logic [1:0] granted;
    logic [N-1:0] rd_ok;
    logic [N-1:0] wr_ok;
    // Password bank access
    logic pwd_we;
    logic [1:0] pwd_sel;
    logic [31:0] pwd_wdata;
    logic [1:0] cmp_sel;
    logic [31:0] cmp_data;
    logic cmp_match;

    modport ctrl (output guard, granted, pwd_we, pwd_sel, pwd_wdata,
                  cmp_sel, cmp_data, input rd_ok, wr_ok, cmp_match);
    modport rights (input guard, granted, output rd_ok, wr_ok);
    modport bank (input pwd_we, pwd_sel, pwd_wdata, cmp_sel, cmp_data,
                  output cmp_match);
endinterface
`default_nettype wire

// >>> rtl/spg_rights.sv
// Per-sector read and write permission decode from guard bytes
`default_nettype none
`include "spg_defines.svh"
module spg_rights import spg_pkg::*; #(
    parameter int N = 16
) (
    // Guard state in, permissions out
    spg_int_if.rights ifc
);
    // -----------------------------------------------------------------
    // Decode
    // -----------------------------------------------------------------
    // Pure logic, so a new guard byte takes effect the same cycle
    for (genvar s = 0; s < N; s++) begin : g_sec
        wire logic locked = ifc.guard[s][`SPG_LOCK_BIT];
        wire logic [1:0] prot = ifc.guard[s][`SPG_PROT_HI:`SPG_PROT_LO];
        wire logic [1:0] psel = ifc.guard[s][`SPG_PSEL_HI:`SPG_PSEL_LO];
        // Sector tied to the presented password [R5] [R12]
        wire logic has_pwd = (psel != `SPG_PSEL_NONE) &&
                             (psel == ifc.granted);
        // Without password: read on 00/01, write on 01 only [R4]
        wire logic free_rd = (prot == `SPG_PROT_PWD_WR) ||
                             (prot == `SPG_PROT_OPEN);
        wire logic free_wr = (prot == `SPG_PROT_OPEN);
        // Unlocked sector is open to all [R3]
        assign ifc.rd_ok[s] = !locked || free_rd || has_pwd;
        assign ifc.wr_ok[s] = !locked || free_wr ||
                              (has_pwd && prot != `SPG_PROT_PWD_RD);
    end
endmodule
`default_nettype wire

// >>> rtl/spg_pwd_bank.sv
// Three 32-bit password slots with write port and compare
`default_nettype none
`include "spg_defines.svh"
module spg_pwd_bank import spg_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // Slot access
    spg_int_if.bank ifc
);
    // -----------------------------------------------------------------
    // Slots
    // -----------------------------------------------------------------
    logic [`SPG_PWD_SLOTS-1:0][31:0] slot_q;
    // Select 1..3 maps to slot 0..2; select 0 is never stored
    wire logic [1:0] wr_idx = ifc.pwd_sel - 2'h1;
    wire logic [1:0] cmp_idx = ifc.cmp_sel - 2'h1;

    for (genvar p = 0; p < `SPG_PWD_SLOTS; p++) begin : g_slot
        // All slots start at zero and are live at once [R9] [R6]
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                slot_q[p] <= `SPG_PWD_RESET;
            end else if (clk_en && ifc.pwd_we && wr_idx == 2'(p)) begin
                slot_q[p] <= ifc.pwd_wdata; // [R7]
            end
        end
    end

    // New value is compared from the next cycle on [R7]
    assign ifc.cmp_match = (ifc.cmp_sel != `SPG_PSEL_NONE) &&
                           (slot_q[cmp_idx] == ifc.cmp_data);

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    pwd_store_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ifc.pwd_we && ifc.pwd_sel != 2'h0
        |=> slot_q[$past(wr_idx)] == $past(ifc.pwd_wdata)) // [R7]
        else $error("password slot did not take written value");
endmodule
`default_nettype wire

// >>> rtl/spg_guard.sv
// Sector password access guard: contactless checks and wired guard area
`default_nettype none
`include "spg_defines.svh"

// Notes on behaviour
// R1: Guard byte: 7:5 zero, psel, prot, lock
// R2: Guard bytes reset to zero
// R3: Protection bits apply only when locked
// R4: Locked codes 00,01,10,11 gate read/write
// R5: Password select 00 none, else 1..3
// R6: Three password slots, numbered one to three
// R7: Password write updates slot, used next
// R8: Password change needs that password presented
// R9: Passwords reset to zero, active at once
// R10: Lock loads bits 4:1, sets lock bit
// R11: Lock of locked sector answers error
// R12: Match grants tied sectors until next present
// R13: Mismatch revokes every granted right
// R14: Read with option flag returns guard byte
// R15: Wired guard reads always allowed
// R16: Wired guard writes need wired password
// R17: Master sets area select for guard area
// R18: Guard bytes at wired addresses 0..15
// R19: Wired guard write takes effect at once
// R20: Block n maps to byte address 4n
// R21: Sector is 32 blocks, checked per sector
// R22: Master clears area select for user memory
// R23: No password presented after reset
// R24: Forbidden access rejected with error
module spg_guard import spg_pkg::*; #(
    parameter int SECTORS = `SPG_SECTORS
) (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // Contactless command
    input wire logic rf_cmd_valid,
    input wire spg_op_t rf_cmd_op,
    input wire logic [8:0] rf_block,
    input wire logic rf_opt_flag,
    input wire logic [1:0] rf_pwd_sel,
    input wire logic [3:0] rf_lock_bits,
    input wire logic [31:0] rf_data,
    // Contactless answer and memory grant
    output logic rf_rsp_valid,
    output logic rf_rsp_err,
    output logic rf_rsp_guard_valid,
    output logic [7:0] rf_rsp_guard,
    output logic rf_mem_go,
    output logic rf_mem_we,
    output logic [10:0] rf_mem_addr,
    // Wired guard-area access
    input wire logic wired_valid,
    input wire logic wired_we,
    input wire logic wired_area_sel,
    input wire logic [10:0] wired_addr,
    input wire logic [7:0] wired_wdata,
    input wire logic wired_pwd_ok,
    output logic wired_ack,
    output logic wired_err,
    output logic [7:0] wired_rdata
);
    // -----------------------------------------------------------------
    // Parameter check
    // -----------------------------------------------------------------
    // The guard area is a fixed 16-byte map and blocks carry 4 sector bits
    if (SECTORS != `SPG_SECTORS) begin : g_bad_sectors
        $error("spg_guard supports exactly 16 sectors");
    end

    // -----------------------------------------------------------------
    // Internal carrier and helpers
    // -----------------------------------------------------------------
    spg_int_if #(.N(SECTORS)) ifc ();

    spg_rights #(.N(SECTORS)) u_rights (
        .ifc (ifc.rights)
    );

    spg_pwd_bank u_bank (
        .clock (clock),
        .rst_n (rst_n),
        .clk_en (clk_en),
        .ifc (ifc.bank)
    );

    logic [SECTORS-1:0][7:0] guard_q;
    logic [SECTORS-1:0][7:0] guard_d;
    logic [1:0] granted_q;
    logic [1:0] granted_d;

    // -----------------------------------------------------------------
    // Contactless decode
    // -----------------------------------------------------------------
    // Sector is the block number over 32 [R21]
    wire logic [3:0] rf_sector = rf_block[8:5];
    wire logic [7:0] rf_guard = guard_q[rf_sector];
    wire logic rf_go = rf_cmd_valid && clk_en;
    wire logic is_rd = rf_cmd_op == spg_op_read;
    wire logic is_wr = rf_cmd_op == spg_op_write;
    wire logic is_lock = rf_cmd_op == spg_op_lock;
    wire logic is_pwr = rf_cmd_op == spg_op_pwd_write;
    wire logic is_pres = rf_cmd_op == spg_op_present;
    wire logic sel_none = rf_pwd_sel == `SPG_PSEL_NONE;

    // Rights of the addressed sector [R21]
    wire logic sec_rd_ok = ifc.rd_ok[rf_sector];
    wire logic sec_wr_ok = ifc.wr_ok[rf_sector];
    // Already locked sector cannot be relocked [R11]
    wire logic lock_bad = rf_guard[`SPG_LOCK_BIT];
    // Slot write only by the holder of that password [R8] [R12]
    wire logic pwr_bad = sel_none || granted_q != rf_pwd_sel;
    wire logic pres_bad = sel_none || !ifc.cmp_match;

    // Error per command kind; unknown kinds are refused [R24]
    wire logic rf_err =
        is_rd ? !sec_rd_ok :
        is_wr ? !sec_wr_ok :
        is_lock ? lock_bad :
        is_pwr ? pwr_bad :
        is_pres ? pres_bad : 1'b1;

    wire logic lock_go = rf_go && is_lock && !lock_bad;
    wire logic pwr_go = rf_go && is_pwr && !pwr_bad;
    wire logic pres_go = rf_go && is_pres && !sel_none;
    wire logic mem_go = rf_go && (is_rd || is_wr) && !rf_err;
    // Block n lives at byte address 4n [R20]
    wire logic [10:0] rf_byte_addr = {rf_block, 2'b00};
    // Fresh lock byte: upper bits zero, lock bit forced [R10] [R1]
    wire logic [7:0] lock_byte = {3'b000, rf_lock_bits, 1'b1};

    // Password bank hookup
    assign ifc.pwd_we = pwr_go; // [R7]
    assign ifc.pwd_sel = rf_pwd_sel;
    assign ifc.pwd_wdata = rf_data;
    assign ifc.cmp_sel = rf_pwd_sel;
    assign ifc.cmp_data = rf_data;
    assign ifc.guard = guard_q;
    assign ifc.granted = granted_q;

    // Match grants that slot, a mismatch revokes all [R12] [R13]
    assign granted_d = !pres_go ? granted_q :
                       ifc.cmp_match ? rf_pwd_sel : `SPG_PSEL_NONE;

    // -----------------------------------------------------------------
    // Wired decode
    // -----------------------------------------------------------------
    // Area select set means guard area; clear is user memory [R17] [R22]
    wire logic in_area = wired_area_sel && wired_addr < `SPG_GUARD_AREA_END;
    wire logic [3:0] w_idx = wired_addr[3:0]; // [R18]
    wire logic w_go = wired_valid && clk_en && in_area;
    // Writes only behind the wired password [R16]
    wire logic w_wr_go = w_go && wired_we && wired_pwd_ok;
    wire logic w_err = wired_we && !wired_pwd_ok;

    // Next guard bytes; wired write beats a same-cycle lock
    for (genvar s = 0; s < SECTORS; s++) begin : g_next
        wire logic hit_w = w_wr_go && w_idx == 4'(s);
        wire logic hit_l = lock_go && rf_sector == 4'(s);
        // Wired write rebuilds the rights from the next cycle [R19] [R1]
        assign guard_d[s] = hit_w ? {3'b000, wired_wdata[4:0]} :
                            hit_l ? lock_byte : guard_q[s]; // [R10]
    end

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    // Guard bytes and grant; reset means nothing presented [R2] [R23]
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            guard_q <= '{default: `SPG_GUARD_RESET};
            granted_q <= `SPG_PSEL_NONE;
        end else if (clk_en) begin
            guard_q <= guard_d;
            granted_q <= granted_d;
        end
    end

    // Contactless answer, one pulse per taken command
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rf_rsp_valid <= 1'b0;
            rf_rsp_err <= 1'b0;
            rf_rsp_guard_valid <= 1'b0;
            rf_rsp_guard <= 8'h00;
        end else if (clk_en) begin
            rf_rsp_valid <= rf_cmd_valid;
            rf_rsp_err <= rf_cmd_valid && rf_err; // [R24] [R11]
            // Guard byte rides with an allowed read [R14]
            rf_rsp_guard_valid <= mem_go && is_rd && rf_opt_flag;
            rf_rsp_guard <= rf_guard;
        end
    end

    // Memory grant: only allowed accesses reach the array [R24]
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rf_mem_go <= 1'b0;
            rf_mem_we <= 1'b0;
            rf_mem_addr <= 11'h000;
        end else if (clk_en) begin
            rf_mem_go <= mem_go;
            rf_mem_we <= mem_go && is_wr;
            rf_mem_addr <= rf_byte_addr; // [R20]
        end
    end

    // Wired answer; reads are never refused [R15]
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wired_ack <= 1'b0;
            wired_err <= 1'b0;
            wired_rdata <= 8'h00;
        end else if (clk_en) begin
            wired_ack <= w_go;
            wired_err <= w_go && w_err; // [R16]
            wired_rdata <= guard_q[w_idx]; // [R18]
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic top_bits_set;
    always_comb begin
        top_bits_set = 1'b0;
        for (int s = 0; s < SECTORS; s++) begin
            top_bits_set = top_bits_set | (|guard_q[s][7:5]);
        end
    end

    guard_top_zero_a: assert property (!top_bits_set) // [R1]
        else $error("guard byte upper bits not zero");
    unlocked_open_a: assert property ( // [R3]
        rf_go && (is_rd || is_wr) && !rf_guard[`SPG_LOCK_BIT]
        |=> rf_rsp_valid && !rf_rsp_err && rf_mem_go)
        else $error("unlocked sector access refused");
    prot_no_write_a: assert property ( // [R4]
        rf_go && is_wr && rf_guard[`SPG_LOCK_BIT] &&
        rf_guard[2:1] == `SPG_PROT_PWD_RD |=> rf_rsp_err && !rf_mem_go)
        else $error("write allowed under code 11");
    lock_load_a: assert property ( // [R10]
        lock_go && !w_wr_go
        |=> guard_q[$past(rf_sector)] == $past(lock_byte) && !rf_rsp_err)
        else $error("lock command did not load guard byte");
    relock_err_a: assert property ( // [R11]
        rf_go && is_lock && lock_bad
        |=> rf_rsp_err && $stable(guard_q))
        else $error("relock of locked sector not refused");
    pwd_change_gate_a: assert property ( // [R8]
        rf_go && is_pwr && granted_q != rf_pwd_sel |=> rf_rsp_err)
        else $error("password change without presentation");
    present_grant_a: assert property ( // [R12]
        rf_go && is_pres && ifc.cmp_match
        |=> granted_q == $past(rf_pwd_sel) && !rf_rsp_err)
        else $error("matching password not granted");
    present_revoke_a: assert property ( // [R13]
        pres_go && !ifc.cmp_match |=> granted_q == `SPG_PSEL_NONE)
        else $error("mismatch did not revoke rights");
    wired_read_a: assert property ( // [R15]
        w_go && !wired_we |=> wired_ack && !wired_err &&
        wired_rdata == $past(guard_q[w_idx]))
        else $error("wired guard read refused");
    wired_write_a: assert property ( // [R16]
        w_go && wired_we && !wired_pwd_ok
        |=> wired_err && guard_q[$past(w_idx)] == $past(guard_q[w_idx]))
        else $error("wired write without password");
    mem_addr_a: assert property ( // [R20]
        mem_go |=> rf_mem_addr == {$past(rf_block), 2'b00})
        else $error("block to byte address mapping wrong");

    // Grant moves only on a presentation
    grant_hold_a: assert property ( // [R12]
        !pres_go |=> $stable(granted_q))
        else $error("grant moved without presentation");
    // Wired byte rebuilds the rights next cycle
    wired_fresh_a: assert property ( // [R19]
        w_wr_go |=> guard_q[$past(w_idx)][4:0] == $past(wired_wdata[4:0]))
        else $error("wired guard write lost");

    // Main scenarios
    present_ok_c: cover property (rf_go && is_pres && ifc.cmp_match);
    lock_ok_c: cover property (lock_go);
    wired_wr_c: cover property (w_wr_go ##1 rf_go && is_rd);
    frozen_c: cover property (rf_cmd_valid && !clk_en);
endmodule
`default_nettype wire

// >>> sim/spg_wired_master.sv
// Two-wire bus master model issuing guard area byte requests
`default_nettype none
module spg_wired_master (
    // Clock
    input wire logic clock,
    // Request towards the guard
    output var logic wired_valid,
    output var logic wired_we,
    output var logic wired_area_sel,
    output var logic [10:0] wired_addr,
    output var logic [7:0] wired_wdata,
    output var logic wired_pwd_ok
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus from time zero
    initial begin
        wired_valid = 1'b0;
        wired_we = 1'b0;
        wired_area_sel = 1'b0;
        wired_addr = 11'h000;
        wired_wdata = 8'h00;
        wired_pwd_ok = 1'b0;
    end

    // One byte request for one clock, then release
    task automatic access(input logic we, input logic area,
                          input logic [10:0] addr, input logic [7:0] data,
                          input logic pwd);
        @(posedge clock);
        #1;
        wired_valid = 1'b1;
        wired_we = we;
        wired_area_sel = area;
        wired_addr = addr;
        wired_wdata = data;
        wired_pwd_ok = pwd;
        @(posedge clock);
        #1;
        // Flip stale lines so old values never pass
        wired_valid = 1'b0;
        wired_addr = ~wired_addr;
        wired_wdata = ~wired_wdata;
    endtask
endmodule
`default_nettype wire

// >>> sim/sector_password_access_guard_tb_top.sv
// Self-checking bench of the sector guard against a reference model
`default_nettype none
module sector_password_access_guard_tb_top import spg_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Signals and reference state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic err;
        logic go;
        logic we;
        logic [10:0] addr;
        logic gv;
        logic [7:0] guard;
    } spg_rsp_t;
    logic clock, rst_n, clk_en, rf_cmd_valid, rf_opt_flag;
    spg_op_t rf_cmd_op;
    logic [8:0] rf_block;
    logic [1:0] rf_pwd_sel;
    logic [3:0] rf_lock_bits;
    logic [31:0] rf_data;
    logic rf_rsp_valid, rf_rsp_err, rf_rsp_guard_valid, rf_mem_go, rf_mem_we;
    logic [7:0] rf_rsp_guard, wired_wdata, wired_rdata;
    logic [10:0] rf_mem_addr, wired_addr;
    logic wired_valid, wired_we, wired_area_sel, wired_pwd_ok;
    logic wired_ack, wired_err;
    logic [7:0] gd [16];
    logic [31:0] pw [4];
    logic [1:0] grant;
    logic [22:0] rq [$];
    logic [9:0] wq [$];
    logic [22:0] ro;
    logic [9:0] wo, wx;
    int bad_count, checks_done;

    spg_guard #(.SECTORS(16)) i_spg_guard (.clock, .rst_n, .clk_en,
        .rf_cmd_valid, .rf_cmd_op, .rf_block, .rf_opt_flag, .rf_pwd_sel,
        .rf_lock_bits, .rf_data, .rf_rsp_valid, .rf_rsp_err,
        .rf_rsp_guard_valid, .rf_rsp_guard, .rf_mem_go, .rf_mem_we,
        .rf_mem_addr, .wired_valid, .wired_we, .wired_area_sel, .wired_addr,
        .wired_wdata, .wired_pwd_ok, .wired_ack, .wired_err, .wired_rdata);
    spg_wired_master i_spg_wired_master (.clock, .wired_valid, .wired_we,
        .wired_area_sel, .wired_addr, .wired_wdata, .wired_pwd_ok);

    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Reference rights {read, write} of one guard byte
    function automatic logic [1:0] rights(input logic [7:0] g);
        logic hv;
        hv = (g[4:3] != 2'h0) && (g[4:3] == grant);
        rights[1] = !g[0] || !g[2] || hv;
        rights[0] = !g[0] || (g[2:1] == 2'h1) || (hv && g[2:1] != 2'h3);
    endfunction

    task automatic cmp_rsp(input logic [22:0] got, input logic [22:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_wired(input logic [9:0] got, input logic [9:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // ----------------------------------------------------------------
    // Drivers; each notes its expected answer
    // ----------------------------------------------------------------
    // Read takes its option flag from bits[0]
    task automatic rf_cmd(input spg_op_t op, input logic [8:0] blk,
                          input logic [1:0] sel, input logic [3:0] bits,
                          input logic [31:0] d);
        logic [7:0] g;
        logic [1:0] ok;
        spg_rsp_t e;
        g = gd[blk[8:5]];
        ok = rights(g);
        e = '0;
        @(posedge clock);
        #1;
        rf_cmd_valid = 1'b1;
        rf_cmd_op = op;
        rf_block = blk;
        rf_opt_flag = bits[0];
        rf_pwd_sel = sel;
        rf_lock_bits = bits;
        rf_data = d;
        case (op)
            spg_op_read, spg_op_write: begin
                e.we = (op == spg_op_write);
                e.go = e.we ? ok[0] : ok[1];
                e.err = !e.go;
                e.addr = e.go ? {blk, 2'b00} : 11'h000;
                e.gv = e.go && !e.we && bits[0];
                e.guard = e.gv ? g : 8'h00;
                e.we = e.we && e.go;
            end
            spg_op_lock: begin
                e.err = g[0];
                if (!g[0]) gd[blk[8:5]] = {3'b000, bits, 1'b1};
            end
            spg_op_pwd_write: begin
                e.err = (sel == 2'h0) || (sel != grant);
                if (!e.err) pw[sel] = d;
            end
            default: begin
                e.err = (sel == 2'h0) || (d != pw[sel]);
                if (sel != 2'h0) grant = e.err ? 2'h0 : sel;
            end
        endcase
        rq.push_back(e);
    endtask

    task automatic rf_idle;
        @(posedge clock);
        #1;
        rf_cmd_valid = 1'b0;
        rf_data = ~rf_data;
    endtask

    // Wired byte access; drops any pending contactless command meanwhile
    task automatic wired(input logic we, input logic area,
                         input logic [10:0] a, input logic [7:0] d,
                         input logic pwd);
        fork
            i_spg_wired_master.access(we, area, a, d, pwd);
            rf_idle;
        join
        if (area && a < 11'h010) begin
            wq.push_back({!we, we && !pwd, we ? 8'h00 : gd[a[3:0]]});
            if (we && pwd) gd[a[3:0]] = {3'b000, d[4:0]};
        end
    endtask

    // Read one random block and write another random block of every sector
    task automatic sweep;
        logic [31:0] r;
        for (int s = 0; s < 16; s++) begin
            r = $urandom;
            rf_cmd(spg_op_read, {s[3:0], r[4:0]}, 2'h0, {3'h0, r[5]}, 0);
            rf_cmd(spg_op_write, {s[3:0], r[10:6]}, 2'h0, 4'h0, r);
        end
    endtask

    task automatic do_reset;
        #1;
        rst_n = 1'b0;
        repeat (10) @(posedge clock);
        #1;
        rst_n = 1'b1;
        gd = '{default: 8'h00};
        pw = '{default: 32'h0};
        grant = 2'h0;
    endtask

    task automatic results;
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Answer watcher: oldest note against each answer
    always @(negedge clock) begin
        if (rf_rsp_valid === 1'b1) begin
            ro = {rf_rsp_err, rf_mem_go, rf_mem_we & rf_mem_go,
                  rf_mem_go ? rf_mem_addr : 11'h000, rf_rsp_guard_valid,
                  rf_rsp_guard_valid ? rf_rsp_guard : 8'h00};
            cmp_rsp(ro, rq.size() != 0 ? rq.pop_front() : ~ro);
        end
        if (wired_ack === 1'b1) begin
            wx = wq.size() != 0 ? wq.pop_front() : 10'h3ff;
            wo = {wx[9], wired_err, wx[9] ? wired_rdata : 8'h00};
            cmp_wired(wo, wx);
        end
    end

    // Hang guard
    initial begin
        repeat (5000) @(posedge clock);
        bad_count++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, 0, 1);
        results;
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] v;
        rst_n = 1'b0;
        clk_en = 1'b1;
        rf_cmd_valid = 1'b0;
        rf_cmd_op = spg_op_read;
        rf_block = 9'h000;
        rf_opt_flag = 1'b0;
        rf_pwd_sel = 2'h0;
        rf_lock_bits = 4'h0;
        rf_data = 32'h0;
        bad_count = 0;
        checks_done = 0;
        v = $urandom(32'h50fa);
        do_reset;
        for (int s = 0; s < 16; s++) wired(0, 1, s[10:0], 0, 0);
        rf_cmd(spg_op_read, 9'h1ff, 2'h0, 4'h1, 0);
        rf_cmd(spg_op_present, 9'h000, 2'h1, 4'h0, 0);
        // Every protection and select code, back to back
        for (int s = 0; s < 16; s++) begin
            rf_cmd(spg_op_lock, {s[3:0], 5'h03}, 2'h0, s[3:0], 0);
        end
        rf_cmd(spg_op_lock, 9'h07f, 2'h0, 4'h0, 0);
        sweep;
        rf_cmd(spg_op_present, 9'h000, 2'h1, 4'h0, 1);
        rf_cmd(spg_op_pwd_write, 9'h000, 2'h2, 4'h0, v);
        sweep;
        rf_cmd(spg_op_present, 9'h000, 2'h2, 4'h0, 0);
        rf_cmd(spg_op_pwd_write, 9'h000, 2'h2, 4'h0, v);
        sweep;
        rf_cmd(spg_op_present, 9'h000, 2'h2, 4'h0, 0);
        for (int s = 1; s < 4; s++) begin
            rf_cmd(spg_op_present, 9'h000, s[1:0], 4'h0, s == 2 ? v : 0);
        end
        rf_cmd(spg_op_present, 9'h000, 2'h0, 4'h0, 0);
        rf_cmd(spg_op_pwd_write, 9'h000, 2'h0, 4'h0, v);
        sweep;
        // Wired side of the guard area
        wired(1, 1, 11'h003, 8'hff, 0);
        wired(1, 1, 11'h003, 8'he0, 1);
        rf_cmd(spg_op_write, 9'h07f, 2'h0, 4'h0, v);
        wired(1, 1, 11'h003, 8'hff, 1);
        rf_cmd(spg_op_read, 9'h060, 2'h0, 4'h1, 0);
        rf_cmd(spg_op_write, 9'h060, 2'h0, 4'h0, v);
        wired(0, 0, 11'h003, 0, 1);
        wired(0, 1, 11'h010, 0, 1);
        for (int s = 0; s < 16; s++) wired(0, 1, s[10:0], 0, 0);
        // Second reset: state and grant start over
        repeat (3) @(posedge clock);
        do_reset;
        rf_cmd(spg_op_read, 9'h000, 2'h0, 4'h1, 0);
        rf_cmd(spg_op_lock, 9'h000, 2'h0, 4'h6, 0);
        rf_cmd(spg_op_read, 9'h000, 2'h0, 4'h1, 0);
        rf_cmd(spg_op_present, 9'h000, 2'h1, 4'h0, 0);
        rf_cmd(spg_op_read, 9'h01f, 2'h0, 4'h1, 0);
        repeat (2) rf_idle;
        clk_en = 1'b0;
        rf_cmd(spg_op_read, 9'h020, 2'h0, 4'h1, 0);
        repeat (3) @(posedge clock);
        #1 clk_en = 1'b1;
        rf_idle;
        repeat (3) @(posedge clock);
        if (rq.size() != 0 || wq.size() != 0) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time,
                     rq.size() + wq.size(), 0);
        end
        results;
    end
endmodule
`default_nettype wire
